// File: hdl/dcff_top.sv
// The register addresses and the AHB-Lite register port were chosen for this implementation.
module dcff_top
  import dcff_pkg::*;
#(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 9
)
(
  // System
  input  wire logic                MCLK,
  input  wire logic                RST,
  // AHB-Lite slave
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  // Write side
  input  wire logic                WRITE_CLOCK,
  input  wire logic                WRITE_ENABLE_IN,
  input  wire logic [DATA_W-1:0]   WRITE_DATA_IN,
  output logic                     FULL,
  output logic                     ALMOST_FULL_FLAG,
  output logic                     WRITE_OVERFLOW_ERROR,
  output logic      [ADDR_W:0]     WRITE_POINTER_COUNT,
  // Read side
  input  wire logic                READ_CLOCK,
  input  wire logic                READ_ENABLE_IN,
  output logic      [DATA_W-1:0]   DATA_OUT,
  output logic                     EMPTY,
  output logic                     ALMOST_EMPTY_FLAG,
  output logic                     READ_UNDERFLOW_ERROR,
  output logic      [ADDR_W:0]     READ_POINTER_COUNT,
  // Interrupt
  output logic                     IRQ
);

  localparam int PTR_W = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int SW    = DATA_W + 4;
  localparam int CMP_W = DCFF_THR_W + 1;
  localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
  localparam logic [CMP_W-1:0] DEPTH_C = CMP_W'(DEPTH);

  // Pin synchronisers and link edge detection
  logic [SW-1:0]     pin_s1_reg;
  logic [SW-1:0]     pin_s2_reg;
  logic [1:0]        clk_d_reg;
  logic              wclk_s;
  logic              rclk_s;
  logic              wen_s;
  logic              ren_s;
  logic [DATA_W-1:0] wdata_s;
  logic              wr_evt;
  logic              rd_evt;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      clk_d_reg  <= '0;
    end
    else
    begin
      pin_s1_reg <= {WRITE_CLOCK, READ_CLOCK, WRITE_ENABLE_IN,
                     READ_ENABLE_IN, WRITE_DATA_IN};
      pin_s2_reg <= pin_s1_reg;
      clk_d_reg  <= pin_s2_reg[SW-1 -: 2];
    end
  end

  assign wclk_s  = pin_s2_reg[SW-1];
  assign rclk_s  = pin_s2_reg[SW-2];
  assign wen_s   = pin_s2_reg[SW-3];
  assign ren_s   = pin_s2_reg[SW-4];
  assign wdata_s = pin_s2_reg[DATA_W-1:0];
  assign wr_evt  = wclk_s & ~clk_d_reg[1]; // R01
  assign rd_evt  = rclk_s & ~clk_d_reg[0]; // R01

  // Software controls
  logic                  first_word_preview_mode_reg;
  logic [DCFF_THR_W-1:0] ae_off_reg;
  logic [DCFF_THR_W-1:0] af_off_reg;
  logic [DCFF_EV_N-1:0]  int_stat_reg;
  logic [DCFF_EV_N-1:0]  int_en_reg;
  logic [DCFF_EV_N-1:0]  int_clr;
  logic [DCFF_EV_N-1:0]  evt;

  // Storage
  logic [DATA_W-1:0] mem_reg [DEPTH];

  // Write side state
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] wr_ptr_next;
  logic [PTR_W-1:0] rd_w1_reg;
  logic [PTR_W-1:0] rd_w2_reg;
  logic [PTR_W-1:0] wr_level;
  logic             full_reg;
  logic             almost_full_flag_reg;
  logic             wr_err_reg;
  logic             wr_ok;

  assign wr_ok       = wr_evt & wen_s & ~full_reg; // R10
  assign wr_ptr_next = wr_ok ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
  assign wr_level    = wr_ptr_next - rd_w2_reg;

  always_ff @(posedge MCLK)
  begin
    if (wr_ok)
      mem_reg[wr_ptr_reg[ADDR_W-1:0]] <= wdata_s; // R05
  end

  always_ff @(posedge MCLK)
  begin
    if (RST) // R04 R09
    begin
      wr_ptr_reg <= '0;
      rd_w1_reg  <= '0;
      rd_w2_reg  <= '0;
      full_reg   <= 1'b0;
      almost_full_flag_reg  <= 1'b0;
      wr_err_reg <= 1'b0;
    end
    else if (wr_evt) // R03
    begin
      rd_w1_reg  <= rd_ptr_reg;
      rd_w2_reg  <= rd_w1_reg;
      wr_ptr_reg <= wr_ptr_next;
      full_reg   <= (wr_level == DEPTH_P); // R12
      almost_full_flag_reg  <= (CMP_W'(wr_level) + CMP_W'(af_off_reg) >= DEPTH_C);
      wr_err_reg <= wen_s & full_reg; // R10
    end
  end

  // Read side state
  logic [PTR_W-1:0]  rd_ptr_reg;
  logic [PTR_W-1:0]  rd_ptr_next;
  logic [PTR_W-1:0]  wr_r1_reg;
  logic [PTR_W-1:0]  wr_r2_reg;
  logic [PTR_W-1:0]  rd_level;
  logic              core_empty_reg;
  logic              out_valid_reg;
  logic              almost_empty_flag_reg;
  logic              rd_err_reg;
  logic [DATA_W-1:0] dout_reg;
  logic              empty_o;
  logic              pop;

  // Preview mode refills the output stage without a read
  assign pop = rd_evt & ~core_empty_reg &
               (first_word_preview_mode_reg ? (~out_valid_reg | ren_s) : ren_s); // R07
  assign empty_o     = first_word_preview_mode_reg ? ~out_valid_reg : core_empty_reg;
  assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  assign rd_level    = wr_r2_reg - rd_ptr_next;

  always_ff @(posedge MCLK)
  begin
    if (RST) // R04 R09
    begin
      rd_ptr_reg     <= '0;
      wr_r1_reg      <= '0;
      wr_r2_reg      <= '0;
      core_empty_reg <= 1'b1;
      out_valid_reg  <= 1'b0;
      almost_empty_flag_reg     <= 1'b1;
      rd_err_reg     <= 1'b0;
      dout_reg       <= '0;
    end
    else if (rd_evt) // R02
    begin
      wr_r1_reg      <= wr_ptr_reg; // R08
      wr_r2_reg      <= wr_r1_reg;
      rd_ptr_reg     <= rd_ptr_next;
      core_empty_reg <= (wr_r2_reg == rd_ptr_next); // R06
      almost_empty_flag_reg     <= (CMP_W'(rd_level) <= CMP_W'(ae_off_reg));
      rd_err_reg     <= ren_s & empty_o; // R11
      out_valid_reg  <= first_word_preview_mode_reg & (pop | (out_valid_reg & ~ren_s));
      if (pop)
        dout_reg <= mem_reg[rd_ptr_reg[ADDR_W-1:0]]; // R07 R11
    end
  end

  assign FULL                 = full_reg;
  assign ALMOST_FULL_FLAG     = almost_full_flag_reg;
  assign WRITE_OVERFLOW_ERROR = wr_err_reg;
  assign WRITE_POINTER_COUNT  = wr_ptr_reg;
  assign EMPTY                = empty_o;
  assign ALMOST_EMPTY_FLAG    = almost_empty_flag_reg;
  assign READ_UNDERFLOW_ERROR = rd_err_reg;
  assign READ_POINTER_COUNT   = rd_ptr_reg;
  assign DATA_OUT             = dout_reg;

  // Interrupt events, set wins over clear
  assign evt[DCFF_EV_READ_UNDERFLOW_ERROR] = rd_evt & ren_s & empty_o;
  assign evt[DCFF_EV_WRITE_OVERFLOW_ERROR] = wr_evt & wen_s & full_reg;
  assign evt[DCFF_EV_FULL]  = wr_evt & (wr_level == DEPTH_P) & ~full_reg;
  assign evt[DCFF_EV_EMPTY] = rd_evt & (wr_r2_reg == rd_ptr_next) &
                              ~core_empty_reg;

  always_ff @(posedge MCLK)
  begin
    if (RST)
      int_stat_reg <= '0;
    else
      int_stat_reg <= (int_stat_reg & ~int_clr) | evt;
  end

  assign IRQ = |(int_stat_reg & int_en_reg);

  // AHB-Lite slave, zero wait states
  logic       wr_pend_reg;
  logic       rd_pend_reg;
  logic [7:0] addr_reg;
  logic       acc;

  assign acc = HSEL & HTRANS[DCFF_HTRANS_ACT_BIT] & HREADY;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= '0;
    end
    else
    begin
      wr_pend_reg <= acc & HWRITE;
      rd_pend_reg <= acc & ~HWRITE;
      if (acc)
        addr_reg <= HADDR[7:0];
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      first_word_preview_mode_reg   <= 1'b0;
      ae_off_reg <= DCFF_AE_RST;
      af_off_reg <= DCFF_AF_RST;
      int_en_reg <= '0;
    end
    else if (wr_pend_reg)
    begin
      case (addr_reg)
        DCFF_CTRL_OFS:   first_word_preview_mode_reg   <= HWDATA[DCFF_CTRL_FIRST_WORD_PREVIEW_MODE_BIT];
        DCFF_AE_OFS:     ae_off_reg <= HWDATA[DCFF_THR_W-1:0];
        DCFF_AF_OFS:     af_off_reg <= HWDATA[DCFF_THR_W-1:0];
        DCFF_INT_EN_OFS: int_en_reg <= HWDATA[DCFF_EV_N-1:0];
        default:         ;
      endcase
    end
  end

  assign int_clr = (wr_pend_reg && addr_reg == DCFF_INT_CLR_OFS) ?
                   HWDATA[DCFF_EV_N-1:0] : '0;

  always_comb
  begin
    HRDATA = '0;
    if (rd_pend_reg)
    begin
      case (addr_reg)
        DCFF_CTRL_OFS:     HRDATA[DCFF_CTRL_FIRST_WORD_PREVIEW_MODE_BIT] = first_word_preview_mode_reg;
        DCFF_AE_OFS:       HRDATA[DCFF_THR_W-1:0] = ae_off_reg;
        DCFF_AF_OFS:       HRDATA[DCFF_THR_W-1:0] = af_off_reg;
        DCFF_STATUS_OFS:
        begin
          HRDATA[DCFF_ST_EMPTY]  = empty_o;
          HRDATA[DCFF_ST_ALMOST_EMPTY_FLAG] = almost_empty_flag_reg;
          HRDATA[DCFF_ST_FULL]   = full_reg;
          HRDATA[DCFF_ST_ALMOST_FULL_FLAG]  = almost_full_flag_reg;
          HRDATA[DCFF_ST_READ_UNDERFLOW_ERROR]  = rd_err_reg;
          HRDATA[DCFF_ST_WRITE_OVERFLOW_ERROR]  = wr_err_reg;
        end
        DCFF_COUNT_OFS:
        begin
          HRDATA[DCFF_CNT_W-1:0] = DCFF_CNT_W'(rd_ptr_reg);
          HRDATA[DCFF_WCNT_LSB +: DCFF_CNT_W] = DCFF_CNT_W'(wr_ptr_reg);
        end
        DCFF_INT_STAT_OFS: HRDATA[DCFF_EV_N-1:0] = int_stat_reg;
        DCFF_INT_EN_OFS:   HRDATA[DCFF_EV_N-1:0] = int_en_reg;
        default:           HRDATA = '0;
      endcase
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // Edge counters that only the checks below read
  logic [2:0] e_cnt_reg;
  logic       e_arm_reg;
  logic [2:0] f_cnt_reg;
  logic       f_arm_reg;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      e_cnt_reg <= '0;
      e_arm_reg <= 1'b0;
      f_cnt_reg <= '0;
      f_arm_reg <= 1'b0;
    end
    else
    begin
      if (wr_ok && wr_ptr_reg == rd_ptr_reg && empty_o)
      begin
        e_arm_reg <= 1'b1;
        e_cnt_reg <= '0;
      end
      else if (!empty_o)
        e_arm_reg <= 1'b0;
      else if (e_arm_reg && rd_evt)
        e_cnt_reg <= e_cnt_reg + 1'b1;
      if (pop && full_reg && !f_arm_reg)
      begin
        f_arm_reg <= 1'b1;
        f_cnt_reg <= '0;
      end
      else if (!full_reg)
        f_arm_reg <= 1'b0;
      else if (f_arm_reg && wr_evt)
        f_cnt_reg <= f_cnt_reg + 1'b1;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  AST_RESET: assert property ( // R04
    disable iff (1'b0)
    RST |=> EMPTY && ALMOST_EMPTY_FLAG && !FULL && !ALMOST_FULL_FLAG &&
            !READ_UNDERFLOW_ERROR && !WRITE_OVERFLOW_ERROR &&
            READ_POINTER_COUNT == '0 && WRITE_POINTER_COUNT == '0)
    else $error("flags or counts not cleared by reset");

  AST_RESET_HOLD: assert property ( // R09
    disable iff (1'b0)
    RST ##1 RST |-> EMPTY && !FULL && !wr_err_reg && !rd_err_reg)
    else $error("empty FIFO not reported under reset");

  AST_WR_SIDE: assert property ( // R03
    !wr_evt |=> $stable(FULL) && $stable(ALMOST_FULL_FLAG) &&
                $stable(WRITE_OVERFLOW_ERROR) && $stable(WRITE_POINTER_COUNT))
    else $error("write side output moved without a write edge");

  AST_RD_SIDE: assert property ( // R02
    !rd_evt |=> $stable(DATA_OUT) && $stable(ALMOST_EMPTY_FLAG) &&
                $stable(READ_UNDERFLOW_ERROR) && $stable(READ_POINTER_COUNT))
    else $error("read side output moved without a read edge");

  AST_STORE: assert property ( // R05
    wr_evt && wen_s && !FULL |=>
      mem_reg[$past(wr_ptr_reg[ADDR_W-1:0])] == $past(wdata_s) &&
      WRITE_POINTER_COUNT == $past(WRITE_POINTER_COUNT) + 1'b1)
    else $error("accepted word not stored");

  AST_WR_ERR: assert property ( // R10
    wr_evt |=> WRITE_OVERFLOW_ERROR == $past(wen_s && FULL) &&
               (!$past(FULL) || $stable(WRITE_POINTER_COUNT)))
    else $error("write error does not follow enable and full");

  AST_RD_ERR: assert property ( // R11
    rd_evt && ren_s && EMPTY && (!first_word_preview_mode_reg || core_empty_reg) |=>
      READ_UNDERFLOW_ERROR && $stable(DATA_OUT) &&
      $stable(READ_POINTER_COUNT))
    else $error("read of empty FIFO not flagged or data moved");

  AST_EMPTY_EDGES: assert property ( // R06 R08
    e_arm_reg && $fell(EMPTY) |->
      (!first_word_preview_mode_reg && (e_cnt_reg == 3'(DCFF_EMPTY_EDGES_STD) ||
                     e_cnt_reg == 3'(DCFF_EMPTY_EDGES_STD + 1))) ||
      (first_word_preview_mode_reg && (e_cnt_reg == 3'(DCFF_EMPTY_EDGES_FIRST_WORD_PREVIEW_MODE) ||
                    e_cnt_reg == 3'(DCFF_EMPTY_EDGES_FIRST_WORD_PREVIEW_MODE + 1))))
    else $error("empty fell at the wrong read edge");

  AST_PREVIEW: assert property ( // R07
    first_word_preview_mode_reg && $fell(EMPTY) |->
      DATA_OUT == mem_reg[$past(rd_ptr_reg[ADDR_W-1:0])])
    else $error("preview word not on data out when empty fell");

  AST_STD_DATA: assert property ( // R07
    !first_word_preview_mode_reg && $changed(DATA_OUT) |-> $past(rd_evt && ren_s && !EMPTY))
    else $error("data out changed without a read in standard mode");

  AST_FULL_EDGES: assert property ( // R12
    f_arm_reg && $fell(FULL) |->
      f_cnt_reg == 3'(DCFF_FULL_EDGES) ||
      f_cnt_reg == 3'(DCFF_FULL_EDGES + 1))
    else $error("full fell at the wrong write edge");

endmodule // dcff_top

// File: pkg/dcff_pkg.sv
// Behaviour
// (R01) Write data and write enable are taken at a rising write clock edge, read enable at a rising read clock edge.
// (R02) Data out, empty, almost empty, read error and read count change only at read clock edges; empty can also change when software switches preview mode.
// (R03) Full, almost full, write error and write count change only at write clock edges.
// (R04) Reset initialises every flag and count directly, without waiting for a link clock edge.
// (R05) A write into an empty FIFO stores the word in the first free location.
// (R06) After a write into an empty FIFO, empty falls at the third read edge, or the fourth in preview mode.
// (R07) In preview mode the first word shows on data out when empty falls; in standard mode only after a read.
// (R08) With nearly coincident write and read edges, empty may fall one read edge later.
// (R09) After reset the FIFO reports empty and almost empty, no full, no errors and zero counts.
// (R10) Write enable while full raises write error at that write edge and drops the word.
// (R11) Read enable while empty raises read error at that read edge and leaves data out unchanged; a preview mode refill at that edge still loads data out.
// (R12) After a read from a full FIFO, full falls at the third write edge, or one edge later.
package dcff_pkg;

  // Register byte offsets
  localparam logic [7:0] DCFF_CTRL_OFS     = 8'h00;
  localparam logic [7:0] DCFF_AE_OFS       = 8'h04;
  localparam logic [7:0] DCFF_AF_OFS       = 8'h08;
  localparam logic [7:0] DCFF_STATUS_OFS   = 8'h0c;
  localparam logic [7:0] DCFF_COUNT_OFS    = 8'h10;
  localparam logic [7:0] DCFF_INT_STAT_OFS = 8'h14;
  localparam logic [7:0] DCFF_INT_CLR_OFS  = 8'h18;
  localparam logic [7:0] DCFF_INT_EN_OFS   = 8'h1c;

  // Field layout
  localparam int DCFF_CTRL_FIRST_WORD_PREVIEW_MODE_BIT = 0;
  localparam int DCFF_THR_W         = 12;
  localparam int DCFF_CNT_W         = 12;
  localparam int DCFF_WCNT_LSB      = 16;
  localparam int DCFF_ST_EMPTY      = 0;
  localparam int DCFF_ST_ALMOST_EMPTY_FLAG     = 1;
  localparam int DCFF_ST_FULL       = 2;
  localparam int DCFF_ST_ALMOST_FULL_FLAG      = 3;
  localparam int DCFF_ST_READ_UNDERFLOW_ERROR      = 4;
  localparam int DCFF_ST_WRITE_OVERFLOW_ERROR      = 5;

  // Interrupt events
  localparam int DCFF_EV_N     = 4;
  localparam int DCFF_EV_READ_UNDERFLOW_ERROR = 0;
  localparam int DCFF_EV_WRITE_OVERFLOW_ERROR = 1;
  localparam int DCFF_EV_FULL  = 2;
  localparam int DCFF_EV_EMPTY = 3;

  // Reset values
  localparam logic [DCFF_THR_W-1:0] DCFF_AE_RST = 12'h004;
  localparam logic [DCFF_THR_W-1:0] DCFF_AF_RST = 12'h004;

  // Link edge counts
  localparam int DCFF_EMPTY_EDGES_STD  = 3;
  localparam int DCFF_EMPTY_EDGES_FIRST_WORD_PREVIEW_MODE = 4;
  localparam int DCFF_FULL_EDGES       = 3;

  localparam int DCFF_HTRANS_ACT_BIT = 1;

endpackage

// File: dv/dcff_user_model.sv
module dcff_user_model #(
  parameter int DATA_W = 36
)
(
  // Control
  input  wire logic              run,
  // Write side
  output logic                   wclk,
  output logic                   wen,
  output logic      [DATA_W-1:0] wdat,
  // Read side
  output logic                   rclk,
  output logic                   ren
);
  timeunit 1ns;
  timeprecision 1ps;

  logic wraw = 1'b0;
  logic rraw = 1'b0;
  logic wrun = 1'b0;
  logic rrun = 1'b0;

  initial
  begin
    wen  = 1'b0;
    wdat = '0;
    ren  = 1'b0;
  end

  // Free link clocks, phase unrelated to the system clock
  initial
  begin
    #13;
    forever #100 wraw = ~wraw;
  end

  initial
  begin
    #61;
    forever #100 rraw = ~rraw;
  end

  // Gate only while low so no runt pulse appears
  always @(negedge wraw) wrun <= run;
  always @(negedge rraw) rrun <= run;
  assign wclk = wraw & wrun;
  assign rclk = rraw & rrun;

  // Set up half a period ahead, release data as its inverse
  task automatic write_word(input logic [DATA_W-1:0] d, input logic e);
    @(negedge wclk);
    wen  <= e;
    wdat <= d;
    @(posedge wclk);
    @(negedge wclk);
    wen  <= 1'b0;
    wdat <= ~d;
  endtask

  task automatic read_word(input logic e);
    @(negedge rclk);
    ren <= e;
    @(posedge rclk);
    @(negedge rclk);
    ren <= 1'b0;
  endtask
endmodule // dcff_user_model

// File: dv/tb_top.sv
module tb_top
  import dcff_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        run  = 1'b0;
  logic        hsel = 1'b0;
  logic        hwr  = 1'b0;
  logic [1:0]  htr  = 2'b00;
  logic [2:0]  hsz  = 3'b000;
  logic [31:0] hadr = 32'h0;
  logic [31:0] hwd  = 32'h0;
  logic [31:0] hrd, q;
  logic        hrdy, hresp, wclk, wen, rclk, ren, irq;
  logic        full, almost_full_flag, write_overflow_error, empty, almost_empty_flag, read_underflow_error;
  logic [35:0] wdat, dout, lastw;
  logic [63:0] rnd;
  logic [9:0]  wcnt, rcnt;
  logic [35:0] exp_q[$];
  logic [7:0]  ofs [8] = '{DCFF_CTRL_OFS, DCFF_AE_OFS, DCFF_AF_OFS,
    DCFF_STATUS_OFS, DCFF_COUNT_OFS, DCFF_INT_STAT_OFS, DCFF_INT_EN_OFS,
    8'h20};
  logic [31:0] rv  [8] = '{32'h0, 32'h4, 32'h4, 32'h3, 32'h0, 32'h0,
    32'h0, 32'h0};
  int          error_cnt = 0;
  int          checked   = 0;
  int          seed      = 82;
  int          cyc = 0, rde = 0, wre = 0, wm = 0, rm = 0, wtot = 0, rtot = 0;

  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  dcff_top dcff_top_inst (
    .MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(hadr), .HTRANS(htr),
    .HWRITE(hwr), .HSIZE(hsz), .HWDATA(hwd), .HREADY(hrdy),
    .HRDATA(hrd), .HREADYOUT(hrdy), .HRESP(hresp),
    .WRITE_CLOCK(wclk), .WRITE_ENABLE_IN(wen), .WRITE_DATA_IN(wdat),
    .FULL(full), .ALMOST_FULL_FLAG(almost_full_flag), .WRITE_OVERFLOW_ERROR(write_overflow_error),
    .WRITE_POINTER_COUNT(wcnt), .READ_CLOCK(rclk), .READ_ENABLE_IN(ren),
    .DATA_OUT(dout), .EMPTY(empty), .ALMOST_EMPTY_FLAG(almost_empty_flag),
    .READ_UNDERFLOW_ERROR(read_underflow_error), .READ_POINTER_COUNT(rcnt), .IRQ(irq));

  dcff_user_model dcff_user_model_inst (.run(run), .wclk(wclk), .wen(wen),
    .wdat(wdat), .rclk(rclk), .ren(ren));

  // Link edge counters; marks taken at enabled edges
  always @(posedge wclk)
  begin
    wre++;
    if (wen === 1'b1) wm = rde;
  end

  always @(posedge rclk)
  begin
    rde++;
    if (ren === 1'b1) rm = wre;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(string nm, logic [35:0] seen, logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Single AHB transfer; read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htr  <= 2'b10;
    hadr <= {24'h000000, a};
    hwr  <= wr;
    hsz  <= 3'b010;
    do @(posedge mclk); while (hrdy !== 1'b1);
    htr <= 2'b00;
    hwd <= d;
    do @(posedge mclk); while (hrdy !== 1'b1);
    q = hrd;
  endtask

  task automatic put_word();
    rnd = {$random(seed), $random(seed)};
    exp_q.push_back(rnd[35:0]);
    wtot++;
    dcff_user_model_inst.write_word(rnd[35:0], 1'b1);
  endtask

  task automatic take_word();
    dcff_user_model_inst.read_word(1'b1);
    rtot++;
    lastw = exp_q.pop_front();
    check("dout", dout, lastw);
  endtask

  task automatic empty_at(input int n, input logic e);
    wait (rde == wm + n);
    #90;
    check("empty", empty, e);
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    run <= 1'b1;
    @(negedge mclk);
    check("flags", {full, almost_full_flag, write_overflow_error, empty, almost_empty_flag, read_underflow_error, wcnt, rcnt},
          {6'b000110, 20'h0});
    for (int i = 0; i < 8; i++)
    begin
      ahb(1'b0, ofs[i], 32'h0);
      check("reg", q, rv[i]);
    end
    rnd = {$random(seed), $random(seed)};
    ahb(1'b1, DCFF_AE_OFS, rnd[31:0]);
    ahb(1'b0, DCFF_AE_OFS, 32'h0);
    check("thr", q, {20'h0, rnd[11:0]});
    ahb(1'b1, DCFF_STATUS_OFS, 32'hffffffff);
    ahb(1'b0, DCFF_STATUS_OFS, 32'h0);
    check("status", q, 32'h3);
    // Standard mode, first word
    put_word();
    empty_at(2, 1'b1);
    empty_at(4, 1'b0);
    check("dout", dout, 36'h0);
    take_word();
    check("cnt", {wcnt, rcnt}, {10'h001, 10'h001});
    // Underflow with interrupt
    ahb(1'b1, DCFF_INT_EN_OFS, 32'h1);
    dcff_user_model_inst.read_word(1'b1);
    check("read_underflow_error", read_underflow_error, 1'b1);
    check("dout", dout, lastw);
    check("irq", irq, 1'b1);
    dcff_user_model_inst.read_word(1'b0);
    check("read_underflow_error", read_underflow_error, 1'b0);
    ahb(1'b1, DCFF_INT_EN_OFS, 32'h0);
    @(negedge mclk);
    check("irq", irq, 1'b0);
    ahb(1'b1, DCFF_INT_EN_OFS, 32'h1);
    @(negedge mclk);
    check("irq", irq, 1'b1);
    ahb(1'b1, DCFF_INT_CLR_OFS, 32'h1);
    @(negedge mclk);
    check("irq", irq, 1'b0);
    // Preview mode
    ahb(1'b1, DCFF_CTRL_OFS, 32'h1);
    put_word();
    empty_at(3, 1'b1);
    empty_at(5, 1'b0);
    lastw = exp_q.pop_front();
    check("dout", dout, lastw);
    dcff_user_model_inst.read_word(1'b1);
    rtot++;
    check("empty", empty, 1'b1);
    ahb(1'b1, DCFF_CTRL_OFS, 32'h0);
    // Fill, overflow, then drain with random stalls
    repeat (512) put_word();
    check("full", {full, almost_full_flag, wcnt}, {2'b11, wtot[9:0]});
    dcff_user_model_inst.write_word(36'h0, 1'b1);
    check("write_overflow_error", {write_overflow_error, wcnt}, {1'b1, wtot[9:0]});
    dcff_user_model_inst.write_word(36'h0, 1'b0);
    check("write_overflow_error", write_overflow_error, 1'b0);
    ahb(1'b0, DCFF_INT_STAT_OFS, 32'h0);
    check("int", q[2:1], 2'b11);
    take_word();
    wait (wre == rm + 2);
    #90;
    check("full", full, 1'b1);
    wait (wre == rm + 4);
    #90;
    check("full", full, 1'b0);
    while (exp_q.size() > 0)
    begin
      if ($random(seed) & 1) dcff_user_model_inst.read_word(1'b0);
      take_word();
    end
    check("end", {empty, wcnt, rcnt}, {1'b1, wtot[9:0], rtot[9:0]});
    // Reset with words held and link clocks stopped
    put_word();
    put_word();
    run <= 1'b0;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(negedge mclk);
    check("flags", {full, almost_full_flag, write_overflow_error, empty, almost_empty_flag, read_underflow_error, wcnt, rcnt},
          {6'b000110, 20'h0});
    give_verdict();
  end
endmodule // tb_top
